// >>> hw/pfmbr_pkg.sv
package pfmbr_pkg;

  // ----------------------------------------------------------------------
  // Port lanes, eight bits each, in the flat pin vectors
  // ----------------------------------------------------------------------
  localparam logic [2:0] IX_ADDR = 3'h0;
  localparam logic [2:0] IX_CTRL = 3'h1;
  localparam logic [2:0] IX_SEL = 3'h2;
  localparam logic [2:0] IX_ANA = 3'h3;
  localparam logic [2:0] IX_PAT = 3'h4;
  localparam logic [2:0] IX_TMR = 3'h5;
  localparam logic [2:0] IX_IRQ = 3'h6;
  localparam logic [2:0] IX_SER = 3'h7;

  // ----------------------------------------------------------------------
  // Register kinds on the access port
  // ----------------------------------------------------------------------
  localparam logic [1:0] KIND_LATCH = 2'h0;
  localparam logic [1:0] KIND_DIR = 2'h1;
  localparam logic [1:0] KIND_FUNC = 2'h2;
  localparam logic [1:0] KIND_PINS = 2'h3;

  // ----------------------------------------------------------------------
  // Bit masks and reset values, lane 7 first
  // ----------------------------------------------------------------------
  localparam logic [63:0] PORT_BITS = 64'h3FFF_0FFF_0F07_FCFF;
  localparam logic [63:0] DIR_BITS = 64'h3FFF_0FFF_0007_FCFF;
  localparam logic [63:0] FUNC_BITS = 64'h2DCC_0EFF_0007_F4FF;
  localparam logic [63:0] FUNC_OUT_MASK = 64'h2D4C_0EFF_0007_E4FF;
  localparam logic [63:0] PD_MASK = 64'h0000_0000_0004_00FF;
  localparam logic [63:0] PU_MASK = 64'h3FFF_0FFF_0003_FC00;
  localparam logic [63:0] REL_MASK = 64'h0000_0000_0007_C4FF;
  localparam logic [63:0] REL_PD = 64'h0000_0000_0000_00FF;
  localparam logic [63:0] LATCH_RST = 64'h3FFF_0FFF_0003_FC00;
  localparam logic [63:0] DIR_RST = 64'h0000_0000_0000_0000;
  localparam logic [63:0] FUNC_RST = 64'h0000_0000_0000_0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------------
  // Bus ownership states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OWN = 3'b001,
    ST_PARK = 3'b010,
    ST_REL = 3'b100
  } pfmbr_bus_t;

endpackage : pfmbr_pkg

// >>> hw/pfmbr_top.sv
`timescale 1ns/1ns
`default_nettype none

// What this block does
// R1: Reset clears address-port latch, direction, function; bits become inputs with pull-down.
// R2: Address-port input bit: latch 1 removes pull-down, latch 0 connects it.
// R3: Direction and function both set drive address bits; software writes both together. Here each register write loads only one of them.
// R4: Reset sets control-port latch to ones, clears direction and function; unused bits stay zero.
// R5: Pull-up pins: input mode pull-up follows latch; direction 1, function 0 is output.
// R6: Third chip-select pin in input mode: pull-down when latch 0, none when 1.
// R7: Software uses wait pin with direction 0 and sampled-wait code in controller.
// R8: Reset makes select-port pins inputs; first two pulled up, third pulled down.
// R9: Select-port direction and function 1 output block strobe, shape chosen per block.
// R10: Analog pins are input only; converter channel field picks the sampled pin.
// R11: Reset makes pattern port inputs with pull-ups, latch ones, function cleared.
// R12: Pattern function bit drives generator 0 on pins 0-3, generator 1 on 4-7.
// R13: Reset makes timer port inputs with pull-ups, function cleared, general ports.
// R14: Timer port: clock input pin 0, timer output pin 1, PWM pins 2 and 3.
// R15: Interrupt port resets to pulled-up inputs, latch ones; function enables timer pins.
// R16: Software sets the interrupt input-enable bit to use interrupt-0 pin.
// R17: Serial outputs need direction and function 1; inputs use 0, latch selects pull-up.
// R18: While bus acknowledge is low, multiplexed address/data pins float.
// R19: At release read and write strobes drive high, then float without pull-up.
// R20: Strobes in function mode drive high, then float with pull-up; port mode unchanged.
// R21: Address pins in function mode drive low, then float with pull-down.
// R22: Third chip-select pin in function mode gets a pull-up while the bus is released.
// R23: Internal memory and I/O access blocked while released; peripherals keep running.
// R24: External resistors hold multiplexed lines and strobes while the bus is released.
// R25: After reset every pin is a general port; two-way pins are inputs.
// R26: Release after request and cycle end; acknowledge low until request withdrawn.
module pfmbr_top (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Register access
  input wire logic REG_WR,
  input wire logic [2:0] REG_PORT,
  input wire logic [1:0] REG_KIND,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Port pins, eight bits per port lane
  input wire logic [63:0] PORT_I,
  output logic [63:0] PORT_O,
  output logic [63:0] PORT_OE,
  output logic [63:0] PORT_PU,
  output logic [63:0] PORT_PD,
  // Dedicated bus pins
  output logic [15:0] AD_O,
  output logic AD_OE,
  output logic RD_N_O,
  output logic WR_N_O,
  output logic STROBE_OE,
  output logic BUS_ACK_N,
  output logic INT_ACCESS_BLOCK,
  // Bus controller side
  input wire logic [15:0] CORE_AD,
  input wire logic CORE_AD_OE,
  input wire logic CORE_RD_N,
  input wire logic CORE_WR_N,
  input wire logic [7:0] CORE_ADDR_P2,
  input wire logic CORE_HWR_N,
  input wire logic CORE_RW,
  input wire logic CORE_RAS_N,
  input wire logic [2:0] CS_N,
  input wire logic [2:0] CAS_N,
  input wire logic [2:0] STROBE_SHAPE,
  input wire logic BUS_CYCLE_END,
  output logic WAIT_N,
  // Peripheral outputs
  input wire logic [3:0] PG0,
  input wire logic [3:0] PG1,
  input wire logic TMR_OUT1,
  input wire logic PWM_OUT0,
  input wire logic PWM_OUT1,
  input wire logic [2:0] TFF_OUT,
  input wire logic SERIAL0_TRANSMIT,
  input wire logic TXD1,
  input wire logic SERIAL0_CLOCK_OUT,
  input wire logic SCLK1_OUT,
  // Peripheral inputs
  input wire logic [1:0] CONV_CHANNEL,
  input wire logic IRQ0_INPUT_ENABLE,
  output logic [3:0] ANALOG_SELECT,
  output logic ANALOG_SAMPLE,
  output logic TIMER_CLOCK_IN0,
  output logic [3:0] TIMER_CLOCKS,
  output logic EXT_IRQ_ZERO,
  output logic [1:0] RXD,
  output logic SERIAL0_CLEAR_TO_SEND_SERIAL0_CLOCK_IN,
  output logic SCLK1_IN
);

  logic [63:0] latch_reg, dir_reg, fn_reg;
  logic [63:0] pin_meta_reg, pin_sync_reg;
  logic [63:0] func_o, sel, rel;
  logic [63:0] o_next, oe_next, pu_next, pd_next;
  logic [5:0] lane;
  logic bus_req, park, released;
  pfmbr_pkg::pfmbr_bus_t bus_reg, bus_next;

  assign lane = {REG_PORT, 3'b000};

  // ----------------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------------
  // Writes are masked so that unused and fixed bits always read as zero.
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      // R1: address port cleared
      // R4: control latch ones
      // R8: select port inputs
      // R11: pattern port pulled up
      // R13: timer port general
      // R15: interrupt port latch ones
      // R25: all pins general inputs
      latch_reg <= pfmbr_pkg::LATCH_RST;
      dir_reg <= pfmbr_pkg::DIR_RST;
      fn_reg <= pfmbr_pkg::FUNC_RST;
    end else if (REG_WR) begin
      // R3: each register written alone
      case (REG_KIND)
        pfmbr_pkg::KIND_LATCH: latch_reg[lane +: 8] <= REG_WDATA & pfmbr_pkg::PORT_BITS[lane +: 8];
        pfmbr_pkg::KIND_DIR: dir_reg[lane +: 8] <= REG_WDATA & pfmbr_pkg::DIR_BITS[lane +: 8];
        pfmbr_pkg::KIND_FUNC: fn_reg[lane +: 8] <= REG_WDATA & pfmbr_pkg::FUNC_BITS[lane +: 8];
        default: latch_reg <= latch_reg;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      REG_RDATA <= pfmbr_pkg::BYTE_ZERO;
    end else begin
      case (REG_KIND)
        pfmbr_pkg::KIND_LATCH: REG_RDATA <= latch_reg[lane +: 8];
        pfmbr_pkg::KIND_DIR: REG_RDATA <= dir_reg[lane +: 8];
        pfmbr_pkg::KIND_FUNC: REG_RDATA <= fn_reg[lane +: 8];
        default: REG_RDATA <= pin_sync_reg[lane +: 8] & pfmbr_pkg::PORT_BITS[lane +: 8];
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      pin_meta_reg <= 64'h0;
      pin_sync_reg <= 64'h0;
    end else begin
      pin_meta_reg <= PORT_I;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Bus release sequencing
  // ----------------------------------------------------------------------
  // The request pin counts only when it is configured as the request input.
  assign bus_req = ~pin_sync_reg[12] & fn_reg[12] & ~dir_reg[12];
  assign park = bus_reg == pfmbr_pkg::ST_PARK;
  assign released = bus_reg == pfmbr_pkg::ST_REL;
  // R23: internal access blocked
  assign INT_ACCESS_BLOCK = bus_reg != pfmbr_pkg::ST_OWN;
  assign BUS_ACK_N = ~released;

  always_comb begin
    bus_next = bus_reg;
    case (bus_reg)
      // R26: release after cycle end
      pfmbr_pkg::ST_OWN: bus_next = (bus_req && BUS_CYCLE_END) ? pfmbr_pkg::ST_PARK : pfmbr_pkg::ST_OWN;
      pfmbr_pkg::ST_PARK: bus_next = pfmbr_pkg::ST_REL;
      pfmbr_pkg::ST_REL: bus_next = bus_req ? pfmbr_pkg::ST_REL : pfmbr_pkg::ST_OWN;
      default: bus_next = pfmbr_pkg::ST_OWN;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      bus_reg <= pfmbr_pkg::ST_OWN;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // ----------------------------------------------------------------------
  // Pin multiplexing
  // ----------------------------------------------------------------------
  // R9: strobe shape per block
  // R12: pattern generators split
  // R14: timer outputs placed
  assign func_o = {
    {2'b00, SCLK1_OUT, 1'b0, TXD1, SERIAL0_CLOCK_OUT, 1'b0, SERIAL0_TRANSMIT},
    {1'b0, TFF_OUT[2], 2'b00, TFF_OUT[1], TFF_OUT[0], 2'b00},
    {4'h0, PWM_OUT1, PWM_OUT0, TMR_OUT1, 1'b0},
    {PG1, PG0},
    8'h00,
    {5'h00, (STROBE_SHAPE & CAS_N) | (~STROBE_SHAPE & CS_N)},
    {CORE_RAS_N, CORE_RW, BUS_ACK_N, 2'b00, CORE_HWR_N, 2'b00},
    CORE_ADDR_P2};

  // R17: function needs direction too
  assign sel = fn_reg & dir_reg & pfmbr_pkg::FUNC_OUT_MASK;
  // Only function-mode strobe and address pins take part in a release.
  assign rel = fn_reg & dir_reg & pfmbr_pkg::REL_MASK;

  always_comb begin
    // R3: address output selected
    o_next = (sel & func_o) | (~sel & latch_reg);
    // R5: direction 1 drives
    oe_next = dir_reg & pfmbr_pkg::PORT_BITS;
    // R5: pull-up follows latch
    pu_next = ~dir_reg & latch_reg & pfmbr_pkg::PU_MASK;
    // R2: pull-down follows inverted latch
    // R6: pull-down on latch 0
    pd_next = ~dir_reg & ~latch_reg & pfmbr_pkg::PD_MASK;
    // R20: strobes park high
    // R21: address parks low
    if (park) begin
      o_next = (o_next & ~rel) | (rel & ~pfmbr_pkg::REL_PD);
    end
    if (released) begin
      // R20: float with pull-up
      // R21: float with pull-down
      // R22: select pin pulled up
      oe_next = oe_next & ~rel;
      pu_next = pu_next | (rel & ~pfmbr_pkg::REL_PD);
      pd_next = (pd_next & ~rel) | (rel & pfmbr_pkg::REL_PD);
    end
  end

  // Registered pins keep glitches from the select logic off the package.
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      PORT_O <= 64'h0;
      PORT_OE <= 64'h0;
      PORT_PU <= 64'h0;
      PORT_PD <= 64'h0;
      AD_O <= 16'h0000;
      AD_OE <= 1'b0;
      RD_N_O <= 1'b1;
      WR_N_O <= 1'b1;
      STROBE_OE <= 1'b0;
    end else begin
      PORT_O <= o_next;
      PORT_OE <= oe_next;
      PORT_PU <= pu_next;
      PORT_PD <= pd_next;
      AD_O <= CORE_AD;
      // R18: data bus floats
      AD_OE <= CORE_AD_OE & ~park & ~released;
      // R19: strobes high, then float
      RD_N_O <= CORE_RD_N | park;
      WR_N_O <= CORE_WR_N | park;
      STROBE_OE <= ~released;
    end
  end

  // ----------------------------------------------------------------------
  // Input functions
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      WAIT_N <= 1'b1;
      ANALOG_SELECT <= 4'h0;
      ANALOG_SAMPLE <= 1'b0;
      TIMER_CLOCK_IN0 <= 1'b0;
      TIMER_CLOCKS <= 4'h0;
      EXT_IRQ_ZERO <= 1'b0;
      RXD <= 2'b11;
      SERIAL0_CLEAR_TO_SEND_SERIAL0_CLOCK_IN <= 1'b1;
      SCLK1_IN <= 1'b1;
    end else begin
      // R7: wait pin as input
      WAIT_N <= pin_sync_reg[11] | dir_reg[11];
      // R10: channel picks pin
      ANALOG_SELECT <= 4'h1 << CONV_CHANNEL;
      ANALOG_SAMPLE <= pin_sync_reg[{4'h6, CONV_CHANNEL}];
      // R14: timer clock input
      TIMER_CLOCK_IN0 <= pin_sync_reg[40] & ~dir_reg[40];
      TIMER_CLOCKS <= {pin_sync_reg[53], pin_sync_reg[52], pin_sync_reg[49], pin_sync_reg[48]};
      // R16: interrupt input gated
      EXT_IRQ_ZERO <= pin_sync_reg[55] & fn_reg[55] & ~dir_reg[55] & IRQ0_INPUT_ENABLE;
      // R17: serial inputs
      RXD <= {pin_sync_reg[60], pin_sync_reg[57]};
      SERIAL0_CLEAR_TO_SEND_SERIAL0_CLOCK_IN <= pin_sync_reg[58];
      SCLK1_IN <= pin_sync_reg[61];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  property p_addr_reset;
    $rose(RESET_N) |-> latch_reg[7:0] == 8'h00 && dir_reg[7:0] == 8'h00 && fn_reg[7:0] == 8'h00;
  endproperty
  a_addr_reset: assert property (p_addr_reset) else $error("address port reset wrong"); // R1
  property p_addr_pull;
    (bus_reg == pfmbr_pkg::ST_OWN) |=> PORT_PD[7:0] == $past(~dir_reg[7:0] & ~latch_reg[7:0]);
  endproperty
  a_addr_pull: assert property (p_addr_pull) else $error("address pull-down wrong"); // R2
  property p_ctrl_reset;
    $rose(RESET_N) |-> latch_reg[15:8] == 8'hFC && dir_reg[15:8] == 8'h00 && fn_reg[15:8] == 8'h00;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control port reset wrong"); // R4
  property p_strobe_shape;
    (bus_reg == pfmbr_pkg::ST_OWN && fn_reg[16] && dir_reg[16])
      |=> PORT_O[16] == $past(STROBE_SHAPE[0] ? CAS_N[0] : CS_N[0]);
  endproperty
  a_strobe_shape: assert property (p_strobe_shape) else $error("chip select strobe wrong"); // R9
  property p_pattern;
    (fn_reg[37] && dir_reg[37] && bus_reg == pfmbr_pkg::ST_OWN) |=> PORT_O[37] == $past(PG1[1]);
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern output wrong"); // R12
  property p_ad_float;
    (bus_reg == pfmbr_pkg::ST_REL) |-> !BUS_ACK_N ##1 !AD_OE;
  endproperty
  a_ad_float: assert property (p_ad_float) else $error("data bus not floated"); // R18
  property p_rdwr_park;
    (bus_reg == pfmbr_pkg::ST_PARK) |=> RD_N_O && WR_N_O && STROBE_OE ##1 !STROBE_OE;
  endproperty
  a_rdwr_park: assert property (p_rdwr_park) else $error("read/write park wrong"); // R19
  property p_addr_park;
    (bus_reg == pfmbr_pkg::ST_PARK && fn_reg[0] && dir_reg[0] && !REG_WR)
      |=> !PORT_O[0] && PORT_OE[0] ##1 !PORT_OE[0] && PORT_PD[0];
  endproperty
  a_addr_park: assert property (p_addr_park) else $error("address park wrong"); // R21
  property p_cs2_pullup;
    (released && fn_reg[18] && dir_reg[18]) |=> PORT_PU[18] && !PORT_PD[18] && !PORT_OE[18];
  endproperty
  a_cs2_pullup: assert property (p_cs2_pullup) else $error("select pin pull-up wrong"); // R22
  property p_release_order;
    (bus_reg == pfmbr_pkg::ST_OWN && !(bus_req && BUS_CYCLE_END)) |=> BUS_ACK_N && !park;
  endproperty
  a_release_order: assert property (p_release_order) else $error("early bus release"); // R26
endmodule : pfmbr_top
`default_nettype wire

// >>> test/pfmbr_pins.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------
// Board side of the pins: device drive, pulls, other drivers, bus master
// ----------------------------------------------------------------------
module pfmbr_pins (
  // Clock
  input wire logic clk,
  // Device pin controls
  input wire logic [63:0] port_o,
  input wire logic [63:0] port_oe,
  input wire logic [63:0] port_pu,
  input wire logic [63:0] port_pd,
  // Dedicated bus pins
  input wire logic [15:0] ad_o,
  input wire logic ad_oe,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic strobe_oe,
  // Board drivers
  input wire logic bus_req,
  input wire logic [63:0] ext_en,
  input wire logic [63:0] ext_val,
  // Levels back to the device
  output logic [63:0] port_i,
  output logic [15:0] ad_line,
  output logic rd_n_line,
  output logic wr_n_line
);
  // A pin nobody drives or pulls toggles, so a stale level never reads as valid.
  logic [63:0] float_reg = 64'h5555_5555_5555_5555;

  always @(posedge clk) begin
    float_reg <= ~float_reg;
  end

  assign ad_line = ad_oe ? ad_o : 16'hFFFF;
  assign rd_n_line = strobe_oe ? rd_n : 1'h1;
  assign wr_n_line = strobe_oe ? wr_n : 1'h1;

  always_comb begin
    for (int i = 0; i < 64; i++) begin
      if (port_oe[i]) begin
        port_i[i] = port_o[i];
      end else if (i == 12 && bus_req) begin
        port_i[i] = 1'h0;
      end else if (ext_en[i]) begin
        port_i[i] = ext_val[i];
      end else if (port_pu[i]) begin
        port_i[i] = 1'h1;
      end else if (port_pd[i]) begin
        port_i[i] = 1'h0;
      end else begin
        port_i[i] = float_reg[i];
      end
    end
  end

endmodule : pfmbr_pins

`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end

module tb;
  typedef struct {logic [2:0] ln; logic [23:0] ldf; logic [7:0] o, oe, pu, pd, rd;} pfmbr_row_t;
  logic REF_CLK = 1'h0;
  logic RESET_N = 1'h0;
  logic REG_WR = 1'h0;
  logic [2:0] REG_PORT = 3'h0;
  logic [1:0] REG_KIND = 2'h0;
  logic [7:0] REG_WDATA = 8'h00;
  logic [15:0] CORE_AD = 16'h3C5A;
  logic CORE_AD_OE = 1'h0, CORE_RD_N = 1'h1, CORE_WR_N = 1'h1, CORE_HWR_N = 1'h0, CORE_RW = 1'h0, CORE_RAS_N = 1'h0;
  logic [7:0] CORE_ADDR_P2 = 8'hA5;
  logic [2:0] CS_N = 3'h5, CAS_N = 3'h2, STROBE_SHAPE = 3'h4, TFF_OUT = 3'h7;
  logic BUS_CYCLE_END = 1'h0, IRQ0_INPUT_ENABLE = 1'h0;
  logic [3:0] PG0 = 4'h5, PG1 = 4'hA;
  logic TMR_OUT1 = 1'h1, PWM_OUT0 = 1'h0, PWM_OUT1 = 1'h1, SERIAL0_TRANSMIT = 1'h1, TXD1 = 1'h1, SERIAL0_CLOCK_OUT = 1'h1, SCLK1_OUT = 1'h1;
  logic [1:0] CONV_CHANNEL = 2'h0;
  logic [63:0] PORT_I, PORT_O, PORT_OE, PORT_PU, PORT_PD;
  logic [7:0] REG_RDATA;
  logic [15:0] AD_O;
  logic AD_OE, RD_N_O, WR_N_O, STROBE_OE, BUS_ACK_N, INT_ACCESS_BLOCK, WAIT_N, ANALOG_SAMPLE;
  logic TIMER_CLOCK_IN0, EXT_IRQ_ZERO, SERIAL0_CLEAR_TO_SEND_SERIAL0_CLOCK_IN, SCLK1_IN;
  logic [3:0] ANALOG_SELECT, TIMER_CLOCKS;
  logic [1:0] RXD;
  logic [15:0] ad_line;
  logic rd_n_line, wr_n_line;
  logic bus_req = 1'h0;
  logic [63:0] ext_en = 64'h0, ext_val = 64'h0;
  logic [7:0] v;
  logic [5:0] b;
  int checks = 0, mismatches = 0, cycles = 0;

  // ----------------------------------------------------------------------
  // Lane settings: lane, {latch, dir, func}, then O, OE, PU, PD, dir read
  // ----------------------------------------------------------------------
  pfmbr_row_t rows [13] = '{
    '{3'h0, 24'h0F_00_00, 8'h00, 8'h00, 8'h00, 8'hF0, 8'h00},
    '{3'h0, 24'h00_FF_FF, 8'hA5, 8'hFF, 8'h00, 8'h00, 8'hFF},
    '{3'h1, 24'h00_00_00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
    '{3'h1, 24'h08_0F_00, 8'h08, 8'h0C, 8'h00, 8'h00, 8'h0C},
    '{3'h2, 24'h03_00_00, 8'h00, 8'h00, 8'h03, 8'h04, 8'h00},
    '{3'h2, 24'h04_07_07, 8'h01, 8'h07, 8'h00, 8'h00, 8'h07},
    '{3'h3, 24'h00_FF_FF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
    '{3'h4, 24'h30_FF_0F, 8'h35, 8'hFF, 8'h00, 8'h00, 8'hFF},
    '{3'h4, 24'h03_FF_F0, 8'hA3, 8'hFF, 8'h00, 8'h00, 8'hFF},
    '{3'h5, 24'h00_0E_0E, 8'h0A, 8'h0E, 8'h00, 8'h00, 8'h0E},
    '{3'h6, 24'h00_4C_4C, 8'h4C, 8'h4C, 8'h00, 8'h00, 8'h4C},
    '{3'h7, 24'h12_00_00, 8'h00, 8'h00, 8'h12, 8'h00, 8'h00},
    '{3'h7, 24'h00_2D_2D, 8'h2D, 8'h2D, 8'h00, 8'h00, 8'h2D}
  };

  pfmbr_top dut (.REF_CLK, .RESET_N, .REG_WR, .REG_PORT, .REG_KIND, .REG_WDATA, .REG_RDATA, .PORT_I, .PORT_O,
    .PORT_OE, .PORT_PU, .PORT_PD, .AD_O, .AD_OE, .RD_N_O, .WR_N_O, .STROBE_OE, .BUS_ACK_N, .INT_ACCESS_BLOCK,
    .CORE_AD, .CORE_AD_OE, .CORE_RD_N, .CORE_WR_N, .CORE_ADDR_P2, .CORE_HWR_N, .CORE_RW, .CORE_RAS_N, .CS_N,
    .CAS_N, .STROBE_SHAPE, .BUS_CYCLE_END, .WAIT_N, .PG0, .PG1, .TMR_OUT1, .PWM_OUT0, .PWM_OUT1, .TFF_OUT, .SERIAL0_TRANSMIT,
    .TXD1, .SERIAL0_CLOCK_OUT, .SCLK1_OUT, .CONV_CHANNEL, .IRQ0_INPUT_ENABLE, .ANALOG_SELECT, .ANALOG_SAMPLE,
    .TIMER_CLOCK_IN0, .TIMER_CLOCKS, .EXT_IRQ_ZERO, .RXD, .SERIAL0_CLEAR_TO_SEND_SERIAL0_CLOCK_IN, .SCLK1_IN);

  pfmbr_pins pins (.clk(REF_CLK), .port_o(PORT_O), .port_oe(PORT_OE), .port_pu(PORT_PU), .port_pd(PORT_PD),
    .ad_o(AD_O), .ad_oe(AD_OE), .rd_n(RD_N_O), .wr_n(WR_N_O), .strobe_oe(STROBE_OE), .bus_req(bus_req),
    .ext_en(ext_en), .ext_val(ext_val), .port_i(PORT_I), .ad_line(ad_line), .rd_n_line(rd_n_line),
    .wr_n_line(wr_n_line));

  always #2 REF_CLK = ~REF_CLK;

  // ----------------------------------------------------------------------
  // Drivers and closing
  // ----------------------------------------------------------------------
  // Latch, direction and function go back to back in one strobe run.
  // registers back to back
  task automatic wr3(input logic [2:0] ln, input logic [23:0] ldf);
    for (int k = 0; k < 3; k++) begin
      @(negedge REF_CLK);
      REG_WR = 1'h1;
      REG_PORT = ln;
      REG_KIND = 2'(k);
      REG_WDATA = ldf[23 - 8 * k -: 8];
    end
    @(negedge REF_CLK);
    REG_WR = 1'h0;
  endtask : wr3

  task automatic rd(input logic [2:0] ln, input logic [1:0] k, output logic [7:0] q);
    @(negedge REF_CLK);
    REG_PORT = ln;
    REG_KIND = k;
    @(negedge REF_CLK);
    q = REG_RDATA;
  endtask : rd

  task automatic wait_ack(input logic lv);
    int n;
    n = 0;
    while (BUS_ACK_N !== lv && n < 12) begin
      @(negedge REF_CLK);
      n++;
    end
  endtask : wait_ack

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    repeat (6) @(negedge REF_CLK);
    RESET_N = 1'h1;
    @(negedge REF_CLK);
    `CHK(PORT_PU, pfmbr_pkg::PU_MASK)
    `CHK(PORT_PD, pfmbr_pkg::PD_MASK)
    `CHK(PORT_OE, 64'h0)
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), pfmbr_pkg::KIND_LATCH, v);
      `CHK(v, pfmbr_pkg::LATCH_RST[8 * i +: 8])
      rd(3'(i), pfmbr_pkg::KIND_FUNC, v);
      `CHK(v, 8'h00)
    end
    foreach (rows[i]) begin
      wr3(rows[i].ln, rows[i].ldf);
      rd(rows[i].ln, pfmbr_pkg::KIND_DIR, v);
      `CHK(v, rows[i].rd)
      b = {rows[i].ln, 3'h0};
      `CHK(PORT_OE[b +: 8], rows[i].oe)
      `CHK(PORT_O[b +: 8] & rows[i].oe, rows[i].o)
      `CHK(PORT_PU[b +: 8], rows[i].pu)
      `CHK(PORT_PD[b +: 8], rows[i].pd)
    end
    ext_en = 64'h1280_0100_0F00_0800;
    ext_val = 64'h1080_0100_0500_0000;
    wr3(3'h6, 24'hFF_00_80);
    wr3(3'h1, 24'hFC_00_00);
    IRQ0_INPUT_ENABLE = 1'h1;
    SERIAL0_CLOCK_OUT = 1'h0;
    SCLK1_OUT = 1'h0;
    repeat (4) @(negedge REF_CLK);
    `CHK({TIMER_CLOCKS, RXD, SERIAL0_CLEAR_TO_SEND_SERIAL0_CLOCK_IN, SCLK1_IN}, 8'hF8)
    `CHK(TIMER_CLOCK_IN0, 1'h1)
    `CHK(EXT_IRQ_ZERO, 1'h1)
    `CHK(WAIT_N, 1'h0)
    IRQ0_INPUT_ENABLE = 1'h0;
    repeat (2) @(negedge REF_CLK);
    `CHK(EXT_IRQ_ZERO, 1'h0)
    rd(3'h3, pfmbr_pkg::KIND_PINS, v);
    `CHK(v, 8'h05)
    for (int c = 0; c < 4; c++) begin
      CONV_CHANNEL = 2'(c);
      repeat (2) @(negedge REF_CLK);
      `CHK(ANALOG_SELECT, 4'h1 << c)
      `CHK(ANALOG_SAMPLE, ~c[0])
    end
    wr3(3'h0, 24'h00_FF_FF);
    wr3(3'h1, 24'hFC_CC_D4);
    wr3(3'h2, 24'h07_07_07);
    CORE_AD_OE = 1'h1;
    CORE_RD_N = 1'h0;
    CORE_WR_N = 1'h0;
    bus_req = 1'h1;
    repeat (8) @(negedge REF_CLK);
    `CHK({BUS_ACK_N, AD_OE}, 2'h3)
    `CHK({ad_line, rd_n_line, wr_n_line}, 18'h0F168)
    BUS_CYCLE_END = 1'h1;
    wait_ack(1'h0);
    `CHK({BUS_ACK_N, INT_ACCESS_BLOCK, AD_OE}, 3'h2)
    `CHK({RD_N_O, WR_N_O, STROBE_OE}, 3'h7)
    `CHK({PORT_OE[7:0], PORT_O[7:0]}, 16'hFF00)
    `CHK({PORT_OE[18:16], PORT_O[18:16], PORT_O[15:8] & 8'hC4}, 14'h3FC4)
    @(negedge REF_CLK);
    `CHK({STROBE_OE, AD_OE}, 2'h0)
    `CHK({ad_line, rd_n_line, wr_n_line}, 18'h3FFFF)
    `CHK({PORT_OE[7:0], PORT_PD[7:0]}, 16'h00FF)
    `CHK({PORT_OE[18:16], PORT_PU[18:16]}, 6'h07)
    `CHK({PORT_PU[15:8] & 8'hC4, PORT_OE[11]}, 9'h189)
    bus_req = 1'h0;
    wait_ack(1'h1);
    repeat (2) @(negedge REF_CLK);
    `CHK({PORT_OE[7:0], STROBE_OE, AD_OE, INT_ACCESS_BLOCK}, 11'h7FE)
    bus_req = 1'h1;
    wait_ack(1'h0);
    RESET_N = 1'h0;
    repeat (2) @(negedge REF_CLK);
    RESET_N = 1'h1;
    @(negedge REF_CLK);
    `CHK({BUS_ACK_N, STROBE_OE}, 2'h3)
    `CHK(PORT_PU, pfmbr_pkg::PU_MASK)
    bus_req = 1'h0;
    close_out();
  end

endmodule : tb

`default_nettype wire
